// ### hdl/cwl_lo_phase_gen.sv
`timescale 1ns/1ps
// Overview of operation
// - harmonic suppression only in 16x, 8x
// - reset selects 16x mode until reconfigured
// - 16x divides fast clock into sixteen phases
// - carrier clock edge aligns starting phase
// - sixteen-by-eight selector, independent per channel
// - each select step delays 22.5 degrees
// - 8x/4x derive I and Q, 90 degrees apart
// - 8x/4x weight I by cos, Q by sin
// - 1x uses external I/Q, same weighting
// - sum all eight mixer outputs together
module cwl_lo_phase_gen import cwl_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // sampled cw clocks
  input wire cwl_clk_in_t clk_in,
  // configuration
  input wire logic cfg_load,
  input wire cwl_cfg_t cfg,
  // received channel samples, signed
  input wire logic [NUM_CH-1:0][RX_W-1:0] rx,
  // lo and summed outputs
  output logic [NUM_CH-1:0] lo,
  output logic i_clk,
  output logic q_clk,
  output logic hs_active,
  output logic signed [SUM_W-1:0] sum_i,
  output logic signed [SUM_W-1:0] sum_q
);

  typedef struct packed {
    cwl_mode_t mode;
    logic hs_en;
    logic [NUM_CH-1:0][SEL_W-1:0] sel;
    logic [3:0] cnt;
    logic nx_q;
    logic x1_q;
    logic [NUM_CH-1:0] lo;
    logic i_clk;
    logic q_clk;
    logic hs_active;
    logic signed [SUM_W-1:0] sum_i;
    logic signed [SUM_W-1:0] sum_q;
  } cwl_state_t;

  cwl_state_t s;
  cwl_state_t next_s;
  logic nx_rise;
  logic x1_rise;

  // sign-extended table entry
  function automatic logic signed [W_W-1:0] cwl_tab(input logic [3:0] k);
    cwl_tab = W_W'($signed(COS_TAB[k]));
  endfunction

  // helper for checks: plain sum of all channel samples
  function automatic logic signed [SUM_W-1:0] cwl_rx_sum(
    input logic [NUM_CH-1:0][RX_W-1:0] v
  );
    logic signed [SUM_W-1:0] acc;
    acc = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      acc = acc + SUM_W'($signed(v[c]));
    end
    cwl_rx_sum = acc;
  endfunction

  // next-state logic
  always_comb begin
    logic [NUM_PH-1:0] ph;
    logic [3:0] mask;
    logic [3:0] k;
    logic signed [W_W-1:0] cv;
    logic signed [W_W-1:0] sv;
    logic signed [W_W-1:0] w_i;
    logic signed [W_W-1:0] w_q;
    logic signed [PROD_W-1:0] p_i;
    logic signed [PROD_W-1:0] p_q;
    logic signed [SUM_W-1:0] rxe;
    logic signed [SUM_W-1:0] acc_i;
    logic signed [SUM_W-1:0] acc_q;
    ph = '0;
    mask = MASK_16X;
    k = '0;
    cv = '0;
    sv = '0;
    w_i = '0;
    w_q = '0;
    p_i = '0;
    p_q = '0;
    rxe = '0;
    acc_i = '0;
    acc_q = '0;
    next_s = s;
    // settings take effect live, no reset needed
    if (cfg_load) begin
      next_s.mode = cfg.mode;
      next_s.hs_en = cfg.hs_en;
      next_s.sel = cfg.sel;
    end
    // inputs are synchronous, so one stage is enough for edges
    next_s.nx_q = clk_in.nx;
    next_s.x1_q = clk_in.x1;
    nx_rise = clk_in.nx & ~s.nx_q;
    x1_rise = clk_in.x1 & ~s.x1_q;
    unique case (next_s.mode)
      MODE_16X: mask = MASK_16X;
      MODE_8X: mask = MASK_8X;
      MODE_4X: mask = MASK_4X;
      MODE_1X: mask = MASK_1X;
    endcase
    // carrier edge restarts the divider; edges are expected to coincide
    if (x1_rise) begin
      next_s.cnt = RST_CNT;
    end else if (nx_rise) begin
      next_s.cnt = (s.cnt + 4'h1) & mask;
    end
    // sixteen phases, phase p lags by p fast-clock periods
    for (int p = 0; p < NUM_PH; p++) begin
      ph[p] = 4'(next_s.cnt - 4'(p)) < HALF_16;
    end
    // cross-point: each channel picks its own phase
    for (int c = 0; c < NUM_CH; c++) begin
      next_s.lo[c] = ph[next_s.sel[c]];
    end
    // quadrature clocks per mode
    unique case (next_s.mode)
      MODE_16X: begin
        next_s.i_clk = ph[0];
        next_s.q_clk = ph[QTR_16];
      end
      MODE_8X: begin
        next_s.i_clk = next_s.cnt[2:0] < HALF_8;
        next_s.q_clk = 3'(next_s.cnt[2:0] - QTR_8) < HALF_8;
      end
      MODE_4X: begin
        next_s.i_clk = next_s.cnt[1:0] < HALF_4;
        next_s.q_clk = 2'(next_s.cnt[1:0] - QTR_4) < HALF_4;
      end
      MODE_1X: begin
        next_s.i_clk = clk_in.i_ext;
        next_s.q_clk = clk_in.q_ext;
      end
    endcase
    next_s.hs_active = s.hs_en & (s.mode == MODE_16X || s.mode == MODE_8X);
    // mixers use the lo (16x) or the i/q clocks (other modes) driven now, so sums lag them by one cycle
    for (int c = 0; c < NUM_CH; c++) begin
      rxe = SUM_W'($signed(rx[c]));
      if (s.mode == MODE_16X) begin
        acc_i = s.lo[c] ? acc_i + rxe : acc_i - rxe;
      end else begin
        k = s.sel[c];
        cv = cwl_tab(k);
        sv = cwl_tab(k + SIN_OFS);
        // square-wave signs times cos/sin weights
        w_i = (s.i_clk ? cv : -cv) + (s.q_clk ? sv : -sv);
        w_q = (s.q_clk ? cv : -cv) - (s.i_clk ? sv : -sv);
        p_i = PROD_W'($signed(rx[c])) * PROD_W'(w_i);
        p_q = PROD_W'($signed(rx[c])) * PROD_W'(w_q);
        acc_i = acc_i + SUM_W'(p_i);
        acc_q = acc_q + SUM_W'(p_q);
      end
    end
    next_s.sum_i = acc_i;
    next_s.sum_q = acc_q;
  end

  // state register; reset beats the enable
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.mode <= RST_MODE;
      s.hs_en <= RST_HS_EN;
      s.cnt <= RST_CNT;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign lo = s.lo;
  assign i_clk = s.i_clk;
  assign q_clk = s.q_clk;
  assign hs_active = s.hs_active;
  assign sum_i = s.sum_i;
  assign sum_q = s.sum_q;

  // checks
  property p_hs_modes;
    @(posedge clk) disable iff (rst)
      hs_active |-> $past(s.hs_en) && $past(s.mode) inside {MODE_16X, MODE_8X};
  endproperty
  a_hs_modes: assert property (p_hs_modes) else $error("suppression in wrong mode");

  property p_reset_mode;
    @(posedge clk) $fell(rst) |-> s.mode == MODE_16X && s.cnt == RST_CNT;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode not 16x");

  property p_div16;
    @(posedge clk) disable iff (rst)
      ce && !cfg_load && s.mode == MODE_16X && nx_rise && !x1_rise
      |=> s.cnt == 4'($past(s.cnt) + 4'h1);
  endproperty
  a_div16: assert property (p_div16) else $error("16x divider step wrong");

  property p_sync;
    @(posedge clk) disable iff (rst)
      ce && x1_rise |=> s.cnt == RST_CNT;
  endproperty
  a_sync: assert property (p_sync) else $error("carrier edge did not restart");

  // reset clears lo to zero, so the first edge after release is not yet a selector output
  property p_xpoint;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> s.lo[3] == (4'(s.cnt - s.sel[3]) < HALF_16) &&
      s.lo[6] == (4'(s.cnt - s.sel[6]) < HALF_16);
  endproperty
  a_xpoint: assert property (p_xpoint) else $error("lo phase selection wrong");

  property p_quad8;
    @(posedge clk) disable iff (rst)
      s.mode == MODE_8X |-> s.i_clk == (s.cnt[2:0] < HALF_8) &&
        s.q_clk == (3'(s.cnt[2:0] - QTR_8) < HALF_8);
  endproperty
  a_quad8: assert property (p_quad8) else $error("8x quadrature wrong");

  property p_ext1x;
    @(posedge clk) disable iff (rst)
      ce && !cfg_load && s.mode == MODE_1X |=> s.i_clk == $past(clk_in.i_ext) &&
        s.q_clk == $past(clk_in.q_ext);
  endproperty
  a_ext1x: assert property (p_ext1x) else $error("1x external clocks not used");

  property p_weight0;
    @(posedge clk) disable iff (rst)
      ce && s.mode != MODE_16X && s.sel == '0 && s.i_clk && s.q_clk
      |=> sum_i == SUM_W'($past(cwl_rx_sum(rx)) * SUM_W'(FULL_WEIGHT)) && sum_q == sum_i;
  endproperty
  a_weight0: assert property (p_weight0) else $error("iq weighting wrong");

  property p_sum16;
    @(posedge clk) disable iff (rst)
      ce && s.mode == MODE_16X && &s.lo |=> sum_i == $past(cwl_rx_sum(rx));
  endproperty
  a_sum16: assert property (p_sum16) else $error("channel sum wrong");

  property p_cfg;
    @(posedge clk) disable iff (rst)
      ce && cfg_load |=> s.mode == $past(cfg.mode) && s.sel == $past(cfg.sel) &&
        s.hs_en == $past(cfg.hs_en);
  endproperty
  a_cfg: assert property (p_cfg) else $error("settings not applied");

  property p_cov_sync;
    @(posedge clk) disable iff (rst) ce && x1_rise && s.mode == MODE_16X;
  endproperty
  c_cov_sync: cover property (p_cov_sync);

  property p_cov_8x_hs;
    @(posedge clk) disable iff (rst) s.mode == MODE_8X && hs_active;
  endproperty
  c_cov_8x_hs: cover property (p_cov_8x_hs);

  property p_cov_1x;
    @(posedge clk) disable iff (rst) s.mode == MODE_1X && i_clk && !q_clk;
  endproperty
  c_cov_1x: cover property (p_cov_1x);

endmodule // cwl_lo_phase_gen

// ### hdl/cwl_pkg.sv
package cwl_pkg;

  // clock modes, the multiple of the carrier rate on the fast clock input
  typedef enum logic [1:0] {
    MODE_16X,
    MODE_8X,
    MODE_4X,
    MODE_1X
  } cwl_mode_t;

  localparam int NUM_CH = 8;
  localparam int NUM_PH = 16;
  localparam int SEL_W = 4;
  localparam int RX_W = 8;
  localparam int W_W = 10;
  localparam int PROD_W = 18;
  localparam int SUM_W = 21;

  // counter wrap masks per mode
  localparam logic [3:0] MASK_16X = 4'hF;
  localparam logic [3:0] MASK_8X = 4'h7;
  localparam logic [3:0] MASK_4X = 4'h3;
  localparam logic [3:0] MASK_1X = 4'h0;
  localparam logic [3:0] HALF_16 = 4'h8;
  localparam logic [3:0] QTR_16 = 4'h4;
  localparam logic [2:0] HALF_8 = 3'h4;
  localparam logic [2:0] QTR_8 = 3'h2;
  localparam logic [1:0] HALF_4 = 2'h2;
  localparam logic [1:0] QTR_4 = 2'h1;

  // values after reset
  localparam cwl_mode_t RST_MODE = MODE_16X;
  localparam logic RST_HS_EN = 1'b0;
  localparam logic [3:0] RST_CNT = 4'h0;

  // cos(k * 22.5 deg) * 127, signed; sin(k) is cos(k + 12 mod 16)
  localparam logic [NUM_PH-1:0][7:0] COS_TAB = {
    8'h75, 8'h5A, 8'h31, 8'h00, 8'hCF, 8'hA6, 8'h8B, 8'h81,
    8'h8B, 8'hA6, 8'hCF, 8'h00, 8'h31, 8'h5A, 8'h75, 8'h7F
  };
  localparam logic [3:0] SIN_OFS = 4'hC;
  localparam logic [W_W-1:0] FULL_WEIGHT = 10'h07F;

  // software settings, applied on a load strobe
  typedef struct packed {
    cwl_mode_t mode;
    logic hs_en;
    logic [NUM_CH-1:0][SEL_W-1:0] sel;
  } cwl_cfg_t;

  // sampled clock inputs
  typedef struct packed {
    logic nx;
    logic x1;
    logic i_ext;
    logic q_ext;
  } cwl_clk_in_t;

endpackage

// ### test/cwl_src_model.sv
`timescale 1ns/1ps
// carrier clock source: fast clock toggles each cycle, all lines low while stopped
module cwl_src_model import cwl_pkg::*; (
  // clock, reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [4:0] n,
  // clocks to the block, with the count behind them
  output cwl_clk_in_t clk_in,
  output logic [4:0] t_drv,
  output logic on
);
  logic [4:0] t;
  // a 5-bit count wraps evenly for every multiple, so carrier edges stay aligned
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      t <= 5'h00;
      on <= 1'b0;
      clk_in <= '0;
    end else begin
      t <= t + 5'h01;
      t_drv <= t;
      on <= 1'b1;
      clk_in.nx <= ~t[0];
      clk_in.x1 <= (int'(t) % (2 * int'(n))) < int'(n);
      clk_in.i_ext <= (t & 5'h03) < 5'h02;
      clk_in.q_ext <= ((t - 5'h01) & 5'h03) < 5'h02;
    end
  end
endmodule // cwl_src_model

// ### test/cwl_lo_phase_gen_tb_top.sv
`timescale 1ns/1ps
module cwl_lo_phase_gen_tb_top import cwl_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_load = 1'b0;
  logic ce = 1'b1;
  logic run = 1'b0;
  logic [4:0] n = 5'h10;
  cwl_cfg_t cfg = '0;
  logic [NUM_CH-1:0][RX_W-1:0] rx;
  cwl_clk_in_t clk_in;
  logic [NUM_CH-1:0] lo;
  logic i_clk, q_clk, hs_active;
  logic signed [SUM_W-1:0] sum_i, sum_q;
  logic [4:0] t_drv, t0, t1;
  logic on, on0, on1;
  int miscompares = 0;
  int checks_done = 0;

  // clock
  always #2 clk = ~clk;

  cwl_lo_phase_gen i_cwl_lo_phase_gen (.clk(clk), .rst(rst), .ce(ce), .clk_in(clk_in),
    .cfg_load(cfg_load), .cfg(cfg), .rx(rx), .lo(lo), .i_clk(i_clk), .q_clk(q_clk),
    .hs_active(hs_active), .sum_i(sum_i), .sum_q(sum_q));
  cwl_src_model i_cwl_src_model (.clk(clk), .rst(rst), .run(run), .n(n), .clk_in(clk_in),
    .t_drv(t_drv), .on(on));

  // source count the block sampled at this edge and the one before
  always @(posedge clk) begin
    t0 <= t_drv;
    t1 <= t0;
    on0 <= on;
    on1 <= on0;
  end

  // expected {i, q} for a sampled source count
  function automatic logic [1:0] exp_iq(logic [4:0] t);
    int c;
    c = (int'(t) >> 1) & (int'(n) - 1);
    if (n == 5'h01) return {(t & 5'h03) < 5'h02, ((t - 5'h01) & 5'h03) < 5'h02};
    return {c < int'(n) / 2, ((c - int'(n) / 4) & (int'(n) - 1)) < int'(n) / 2};
  endfunction

  function automatic logic exp_lo(logic [4:0] t, int c);
    return (((int'(t) >> 1) - int'(cfg.sel[c])) & 15) < 8;
  endfunction

  // mixer sum: sign flip in 16x, cos/sin weights otherwise
  function automatic int exp_sum(logic [4:0] t, bit q_side);
    int s, ci, si, wi, wq;
    logic [1:0] iq;
    s = 0;
    iq = exp_iq(t);
    for (int c = 0; c < NUM_CH; c++) begin
      ci = $signed(COS_TAB[cfg.sel[c]]);
      si = $signed(COS_TAB[4'(cfg.sel[c] + SIN_OFS)]);
      wi = (iq[1] ? ci : -ci) + (iq[0] ? si : -si);
      wq = (iq[0] ? ci : -ci) - (iq[1] ? si : -si);
      if (cfg.mode == MODE_16X) begin
        wi = exp_lo(t, c) ? 1 : -1;
        wq = 0;
      end
      s += $signed(rx[c]) * (q_side ? wq : wi);
    end
    return s;
  endfunction

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_of_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // start the source from a carrier edge and judge over 70 cycles, two carrier periods at 16x
  task run_check;
    @(posedge clk);
    run <= 1'b1;
    repeat (70) begin
      @(negedge clk);
      if (on0 && on1) begin
        check(32'({i_clk, q_clk}), 32'(exp_iq(t0)));
        if (cfg.mode == MODE_16X) begin
          for (int c = 0; c < NUM_CH; c++) check(32'(lo[c]), 32'(exp_lo(t0, c)));
        end
        check(32'(sum_i), 32'(exp_sum(t1, 1'b0)));
        check(32'(sum_q), 32'(exp_sum(t1, 1'b1)));
      end
    end
    @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task t_default;
    @(negedge clk);
    check(32'(hs_active), 32'h0);
    run_check;
  endtask

  // reconfigure with no reset in between, suppression always requested
  task t_mode(input cwl_mode_t m, input logic [4:0] nn);
    @(posedge clk);
    cfg_load <= 1'b1;
    cfg.mode <= m;
    cfg.hs_en <= 1'b1;
    for (int c = 0; c < NUM_CH; c++) cfg.sel[c] <= 4'(c * 5 + 3 + int'(m) * 2);
    n <= nn;
    @(posedge clk);
    cfg_load <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(32'(hs_active), 32'(m == MODE_16X || m == MODE_8X));
    run_check;
  endtask

  // all channels at phase zero in 8x: full weight on both paths
  task t_sel0;
    @(posedge clk);
    cfg_load <= 1'b1;
    cfg.mode <= MODE_8X;
    cfg.sel <= '0;
    n <= 5'h08;
    @(posedge clk);
    cfg_load <= 1'b0;
    run_check;
  endtask

  // enable low freezes everything, a load during the freeze is ignored
  task t_freeze;
    logic [NUM_CH-1:0] lo_h;
    logic [1:0] iq_h;
    logic [31:0] si_h;
    @(posedge clk);
    run <= 1'b1;
    repeat (8) @(posedge clk);
    ce <= 1'b0;
    cfg_load <= 1'b1;
    cfg.mode <= MODE_4X;
    @(negedge clk);
    lo_h = lo;
    iq_h = {i_clk, q_clk};
    si_h = 32'(sum_i);
    repeat (5) begin
      @(negedge clk);
      check(32'(lo), 32'(lo_h));
      check(32'({i_clk, q_clk}), 32'(iq_h));
      check(32'(sum_i), si_h);
    end
    @(posedge clk);
    cfg_load <= 1'b0;
    cfg.mode <= MODE_8X;
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(32'(hs_active), 32'h1);
    @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // main sequence
  initial begin
    for (int c = 0; c < NUM_CH; c++) rx[c] <= 8'(7 * c - 20);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_default;
    t_mode(MODE_8X, 5'h08);
    t_mode(MODE_4X, 5'h04);
    t_mode(MODE_1X, 5'h01);
    t_mode(MODE_16X, 5'h10);
    t_sel0;
    t_freeze;
    end_of_test;
  end

  // watchdog, about ten times the expected run length
  initial begin
    #20000;
    miscompares++;
    end_of_test;
  end
endmodule // cwl_lo_phase_gen_tb_top
